//--- rtl/hsp_defs.svh
`ifndef HSP_DEFS_SVH
`define HSP_DEFS_SVH

// Reset values of the pin functions
`define HSP_PIN_RESET      1'b1
`define HSP_SPECIAL_ON_RST 1'b1
`define HSP_ATTN_EN_RST    1'b0

// Pin function select code field positions
`define HSP_SEL_RTS_BIT    0
`define HSP_SEL_CTS_BIT    1
`define HSP_SEL_ATTN_BIT   2
`define HSP_SEL_WIDTH      3

// Buffer depth and stop margin for flow control
`define HSP_RX_DEPTH       16
`define HSP_TX_DEPTH       16
`define HSP_RTS_MARGIN     2

`endif

//--- rtl/hsp_fifo_level.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defs.svh"

// Occupancy counter of one internal buffer with overflow detection
module hsp_fifo_level
#(
   parameter int DEPTH = `HSP_RX_DEPTH
)
(
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // Buffer traffic
   input  wire logic                     push,
   input  wire logic                     pop,
   // Status
   output logic [$clog2(DEPTH+1)-1:0]    level,
   output logic                          overflow
);
   localparam int LW = $clog2(DEPTH + 1);
   localparam logic [LW-1:0] FULL_LEVEL = LW'(DEPTH);

   logic [LW-1:0] level_q;
   logic [LW-1:0] level_d;
   wire           is_full = (level_q == FULL_LEVEL);
   wire           lost    = push && is_full && !pop;
   wire           do_pop  = pop && (level_q != '0);
   wire           do_push = push && !lost;

   // Next level from push and pop
   assign level_d = level_q + LW'(do_push) - LW'(do_pop);

   // Level register
   always_ff @(posedge clk)
   begin
      if (rst)
         level_q <= '0;
      else
         level_q <= level_d;
   end

   assign level    = level_q;
   assign overflow = lost;
endmodule
`default_nettype wire

//--- rtl/hsp_pkg.sv
package hsp_pkg;
   // Attention line states
   typedef enum logic [1:0]
   {
      HSP_ATTN_IDLE,
      HSP_ATTN_REPORT,
      HSP_ATTN_HIBERNATE
   } hsp_attn_t;

   // Direction of the serial traffic context
   typedef enum logic
   {
      HSP_CTX_HOST_SENDING,
      HSP_CTX_HOST_IDLE
   } hsp_ctx_t;
endpackage

//--- rtl/hsp_serial_pins.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defs.svh"

// Overview of operation
// - Incoming host data arrives on the host serial input line.
// - Outgoing data goes to the host on the host serial output line.
// - The local receive permit output tells the host if reception is allowed.
// - The remote receive permit input gates the module's transmission.
// - Permit pins and attention line can revert to general-purpose pins.
// - The attention line is open drain: pulled low only, never driven high.
// - When supported, a host low on the idle line forces hibernation.
// - A receive overflow while the host sends pulls the attention line low.
// - A transmit overflow while the host is idle pulls the line low.
// - With no overflow the attention line stays released high.
// - After boot the attention line is released high.
// - On this platform the attention line is ignored and left high.
module hsp_serial_pins
   import hsp_pkg::*;
#(
   parameter int RX_DEPTH   = `HSP_RX_DEPTH,
   parameter int TX_DEPTH   = `HSP_TX_DEPTH,
   parameter int RTS_MARGIN = `HSP_RTS_MARGIN,
   parameter bit ATTN_SUPPORTED = `HSP_ATTN_EN_RST
)
(
   // Clock and reset
   input  wire logic                     CLK,
   input  wire logic                     RST,
   // Serial data pins
   input  wire logic                     HOST_SERIAL_IN,
   output logic                          HOST_SERIAL_OUT,
   // Flow control pins, active low
   output logic                          LOCAL_RECEIVE_PERMIT_N,
   input  wire logic                     REMOTE_RECEIVE_PERMIT_N,
   // Attention hibernate line, open drain
   input  wire logic                     ATTENTION_HIBERNATE_LINE_I,
   output logic                          ATTENTION_HIBERNATE_LINE_O,
   output logic                          ATTENTION_HIBERNATE_LINE_OE,
   // Pin function control
   input  wire logic                     PIN_FUNC_WE,
   input  wire logic [`HSP_SEL_WIDTH-1:0] PIN_FUNCTION_SELECT_CODE,
   // General-purpose use of released pins
   input  wire logic                     GPIO_RTS_OUT,
   input  wire logic                     GPIO_ATTN_PULL_LOW,
   output logic                          GPIO_CTS_IN,
   output logic                          GPIO_ATTN_IN,
   // Internal receive path
   output logic                          RX_BIT,
   output logic                          RX_PUSH_ACCEPT,
   input  wire logic                     RX_PUSH,
   input  wire logic                     RX_POP,
   // Internal transmit path
   input  wire logic                     TX_BIT,
   input  wire logic                     TX_PUSH,
   input  wire logic                     TX_POP,
   output logic                          TX_ALLOWED,
   // Context and status
   input  wire logic                     HOST_SENDING,
   input  wire logic                     OVERFLOW_ACK,
   output logic                          HIBERNATE,
   output logic                          RX_OVERFLOWED,
   output logic                          TX_OVERFLOWED
);
   localparam int RXW = $clog2(RX_DEPTH + 1);
   localparam int TXW = $clog2(TX_DEPTH + 1);
   localparam logic [RXW-1:0] RTS_STOP = RXW'(RX_DEPTH - RTS_MARGIN);

   hsp_attn_t                 state_q;
   hsp_attn_t                 state_d;
   logic [`HSP_SEL_WIDTH-1:0] special_q;
   logic                      rx_ovf_q;
   logic                      tx_ovf_q;
   logic                      attn_prev_q;
   logic                      tx_q;
   logic                      rx_q;
   logic                      rts_q;
   logic                      cts_q;
   logic                      oe_q;
   logic                      gcts_q;
   logic                      gattn_q;
   logic                      hib_q;
   logic                      line_o_q;
   logic [RXW-1:0]            rx_level;
   logic [TXW-1:0]            tx_level;
   logic                      rx_lost;
   logic                      tx_lost;

   // Occupancy of the receive buffer
   hsp_fifo_level #(.DEPTH(RX_DEPTH)) u_rx_level
   (
      .clk      (CLK),
      .rst      (RST),
      .push     (RX_PUSH),
      .pop      (RX_POP),
      .level    (rx_level),
      .overflow (rx_lost)
   );

   // Occupancy of the transmit buffer
   hsp_fifo_level #(.DEPTH(TX_DEPTH)) u_tx_level
   (
      .clk      (CLK),
      .rst      (RST),
      .push     (TX_PUSH),
      .pop      (TX_POP),
      .level    (tx_level),
      .overflow (tx_lost)
   );

   // Attention function usable on this build
   function automatic logic attn_live(input logic special);
      return ATTN_SUPPORTED && special;
   endfunction

   // Pin function decode
   wire rts_special  = special_q[`HSP_SEL_RTS_BIT];
   wire cts_special  = special_q[`HSP_SEL_CTS_BIT];
   wire attn_special = special_q[`HSP_SEL_ATTN_BIT];

   // Overflow events split by traffic context
   wire ctx_sending = HOST_SENDING;
   wire rx_event    = rx_lost && ctx_sending;
   wire tx_event    = tx_lost && !ctx_sending;

   // Host falling edge on the idle line
   wire line_fall   = attn_prev_q && !ATTENTION_HIBERNATE_LINE_I;
   wire host_pull   = line_fall && !oe_q;
   wire hib_req     = attn_live(attn_special) && host_pull;
   wire any_ovf     = rx_ovf_q || tx_ovf_q;

   // Receive permit: low grants, released before full
   wire rts_grant   = (rx_level < RTS_STOP);
   wire rts_next    = rts_special ? !rts_grant : GPIO_RTS_OUT;

   // Attention state transitions
   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         HSP_ATTN_IDLE:
            if (hib_req)
               state_d = HSP_ATTN_HIBERNATE;
            else if (any_ovf && attn_live(attn_special))
               state_d = HSP_ATTN_REPORT;
         HSP_ATTN_REPORT:
            if (hib_req)
               state_d = HSP_ATTN_HIBERNATE;
            else if (!any_ovf || !attn_special)
               state_d = HSP_ATTN_IDLE;
         HSP_ATTN_HIBERNATE:
            if (ATTENTION_HIBERNATE_LINE_I || !attn_special)
               state_d = HSP_ATTN_IDLE;
      endcase
   end

   // Open-drain drive: only ever pulls low
   wire oe_next = attn_special ? (state_d == HSP_ATTN_REPORT)
                               : GPIO_ATTN_PULL_LOW;

   // Pin function select register
   always_ff @(posedge CLK)
   begin
      if (RST)
         special_q <= {`HSP_SEL_WIDTH{`HSP_SPECIAL_ON_RST}};
      else if (PIN_FUNC_WE)
         special_q <= PIN_FUNCTION_SELECT_CODE;
   end

   // Receive overflow flag, event wins over acknowledge
   always_ff @(posedge CLK)
   begin
      if (RST)
         rx_ovf_q <= 1'b0;
      else
         rx_ovf_q <= rx_event || (rx_ovf_q && !OVERFLOW_ACK);
   end

   // Transmit overflow flag, event wins over acknowledge
   always_ff @(posedge CLK)
   begin
      if (RST)
         tx_ovf_q <= 1'b0;
      else
         tx_ovf_q <= tx_event || (tx_ovf_q && !OVERFLOW_ACK);
   end

   // Attention state register
   always_ff @(posedge CLK)
   begin
      if (RST)
         state_q <= HSP_ATTN_IDLE;
      else
         state_q <= state_d;
   end

   // Previous line level for edge detection, idle high
   always_ff @(posedge CLK)
   begin
      if (RST)
         attn_prev_q <= `HSP_PIN_RESET;
      else
         attn_prev_q <= ATTENTION_HIBERNATE_LINE_I;
   end

   // Line pull-down enable
   always_ff @(posedge CLK)
   begin
      if (RST)
         oe_q <= 1'b0;
      else
         oe_q <= oe_next;
   end

   // Hibernation status
   always_ff @(posedge CLK)
   begin
      if (RST)
         hib_q <= 1'b0;
      else
         hib_q <= (state_d == HSP_ATTN_HIBERNATE);
   end

   // Open-drain data level, never high
   always_ff @(posedge CLK)
   begin
      if (RST)
         line_o_q <= 1'b0;
      else
         line_o_q <= 1'b0;
   end

   // Outgoing serial data, idle high in hibernation
   always_ff @(posedge CLK)
   begin
      if (RST)
         tx_q <= `HSP_PIN_RESET;
      else
         tx_q <= hib_q ? `HSP_PIN_RESET : TX_BIT;
   end

   // Incoming serial data
   always_ff @(posedge CLK)
   begin
      if (RST)
         rx_q <= `HSP_PIN_RESET;
      else
         rx_q <= HOST_SERIAL_IN;
   end

   // Local receive permit pin
   always_ff @(posedge CLK)
   begin
      if (RST)
         rts_q <= `HSP_PIN_RESET;
      else
         rts_q <= hib_q ? `HSP_PIN_RESET : rts_next;
   end

   // Transmit gate from the host permit
   always_ff @(posedge CLK)
   begin
      if (RST)
         cts_q <= 1'b0;
      else
         cts_q <= cts_special && !REMOTE_RECEIVE_PERMIT_N
                  && (state_d != HSP_ATTN_HIBERNATE);
   end

   // Host permit pin as a general input
   always_ff @(posedge CLK)
   begin
      if (RST)
         gcts_q <= `HSP_PIN_RESET;
      else
         gcts_q <= REMOTE_RECEIVE_PERMIT_N;
   end

   // Attention line as a general input
   always_ff @(posedge CLK)
   begin
      if (RST)
         gattn_q <= `HSP_PIN_RESET;
      else
         gattn_q <= ATTENTION_HIBERNATE_LINE_I;
   end

   // Pin outputs
   assign HOST_SERIAL_OUT             = tx_q;
   assign LOCAL_RECEIVE_PERMIT_N      = rts_q;
   assign ATTENTION_HIBERNATE_LINE_O  = line_o_q;
   assign ATTENTION_HIBERNATE_LINE_OE = oe_q;
   assign GPIO_CTS_IN                 = gcts_q;
   assign GPIO_ATTN_IN                = gattn_q;

   // Internal status outputs
   assign RX_BIT         = rx_q;
   assign RX_PUSH_ACCEPT = rts_q;
   assign TX_ALLOWED     = cts_q;
   assign HIBERNATE      = hib_q;
   assign RX_OVERFLOWED  = rx_ovf_q;
   assign TX_OVERFLOWED  = tx_ovf_q;
endmodule
`default_nettype wire

//--- tb/hsp_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module hsp_host_model
(
   // Stimulus from bench
   input  wire logic next_bit,
   input  wire logic stall,
   input  wire logic pull_low,
   // Device pins
   input  wire logic dev_o,
   input  wire logic dev_oe,
   input  wire logic permit_n,
   output logic      serial_in,
   output logic      remote_permit_n,
   output logic      line
);
   // Host sends only while permitted, else idles high
   assign serial_in = permit_n ? 1'b1 : next_bit;
   // Host permit, low grants
   assign remote_permit_n = stall;
   // Pulled-up shared line, either side only pulls low
   assign line = !(pull_low || (dev_oe && !dev_o));
endmodule
`default_nettype wire

//--- tb/hsp_serial_pins_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module hsp_serial_pins_monitor
#(
   parameter bit ATTN_SUPPORTED = 1'b0
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST,
   // Serial and flow control
   input wire logic HOST_SERIAL_OUT,
   input wire logic TX_BIT,
   input wire logic LOCAL_RECEIVE_PERMIT_N,
   input wire logic RX_PUSH_ACCEPT,
   input wire logic REMOTE_RECEIVE_PERMIT_N,
   input wire logic TX_ALLOWED,
   // Attention line and status
   input wire logic ATTENTION_HIBERNATE_LINE_O,
   input wire logic ATTENTION_HIBERNATE_LINE_OE,
   input wire logic HIBERNATE,
   input wire logic GPIO_ATTN_PULL_LOW,
   input wire logic RX_PUSH,
   input wire logic TX_PUSH,
   input wire logic HOST_SENDING,
   input wire logic OVERFLOW_ACK,
   input wire logic RX_OVERFLOWED,
   input wire logic TX_OVERFLOWED
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // Flag set steps
   sequence s_rx_set;
      !RX_OVERFLOWED ##1 RX_OVERFLOWED;
   endsequence
   sequence s_tx_set;
      !TX_OVERFLOWED ##1 TX_OVERFLOWED;
   endsequence
   chk_serial_echo: assert property (!HIBERNATE |=>
      HOST_SERIAL_OUT == $past(TX_BIT)) else $error("serial out wrong");
   chk_permit_copy: assert property (
      RX_PUSH_ACCEPT == LOCAL_RECEIVE_PERMIT_N) else $error("accept wrong");
   chk_tx_gate: assert property (
      REMOTE_RECEIVE_PERMIT_N |=> !TX_ALLOWED) else $error("tx not gated");
   chk_open_drain: assert property (
      ATTENTION_HIBERNATE_LINE_O == 1'b0) else $error("line driven high");
   chk_attn_quiet: assert property (!ATTN_SUPPORTED && !GPIO_ATTN_PULL_LOW
      |=> !ATTENTION_HIBERNATE_LINE_OE && !HIBERNATE) else $error("line used");
   chk_rx_cause: assert property (s_rx_set |->
      $past(RX_PUSH && HOST_SENDING)) else $error("rx flag no cause");
   chk_tx_cause: assert property (s_tx_set |->
      $past(TX_PUSH && !HOST_SENDING)) else $error("tx flag no cause");
   chk_flag_clear: assert property (OVERFLOW_ACK && !RX_PUSH && !TX_PUSH
      |=> !RX_OVERFLOWED && !TX_OVERFLOWED) else $error("flags not cleared");
   chk_boot_idle: assert property ($fell(RST) |-> HOST_SERIAL_OUT &&
      LOCAL_RECEIVE_PERMIT_N && !ATTENTION_HIBERNATE_LINE_OE)
      else $error("boot state wrong");
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "hsp_defs.svh"
module tb_top;
   import hsp_pkg::*;
   logic       clk = 1'b0, rst = 1'b1, hbit = 1'b1, stall = 1'b0;
   logic       pull = 1'b0, we = 1'b0, rts = 1'b0, rxp = 1'b0;
   logic       txb = 1'b1, txp = 1'b0, snd = 1'b1, ack = 1'b0, gpl = 1'b0;
   logic [2:0] sel = 3'h7;
   wire        sin, sout, perm, rem, line, ao, aoe, cts, ain, rxb;
   wire        acc, txa, hib, rxo, txo;
   int         fail_count = 0, n_compared = 0;
   // Rows: sel, rts, stall, txb, hbit, exp permit, exp tx allowed, exp cts
   logic [9:0] rows [6] = '{10'h38A, 10'h3B1, 10'h356, 10'h30A,
                            10'h2B1, 10'h0D0};
   hsp_serial_pins u_hsp_serial_pins (.CLK(clk), .RST(rst),
      .HOST_SERIAL_IN(sin), .HOST_SERIAL_OUT(sout),
      .LOCAL_RECEIVE_PERMIT_N(perm), .REMOTE_RECEIVE_PERMIT_N(rem),
      .ATTENTION_HIBERNATE_LINE_I(line), .ATTENTION_HIBERNATE_LINE_O(ao),
      .ATTENTION_HIBERNATE_LINE_OE(aoe), .PIN_FUNC_WE(we),
      .PIN_FUNCTION_SELECT_CODE(sel), .GPIO_RTS_OUT(rts),
      .GPIO_ATTN_PULL_LOW(gpl), .GPIO_CTS_IN(cts), .GPIO_ATTN_IN(ain),
      .RX_BIT(rxb), .RX_PUSH_ACCEPT(acc), .RX_PUSH(rxp), .RX_POP(1'b0),
      .TX_BIT(txb), .TX_PUSH(txp), .TX_POP(1'b0), .TX_ALLOWED(txa),
      .HOST_SENDING(snd), .OVERFLOW_ACK(ack), .HIBERNATE(hib),
      .RX_OVERFLOWED(rxo), .TX_OVERFLOWED(txo));
   hsp_host_model u_hsp_host_model (.next_bit(hbit), .stall(stall),
      .pull_low(pull), .dev_o(ao), .dev_oe(aoe), .permit_n(perm),
      .serial_in(sin), .remote_permit_n(rem), .line(line));
   always #2.5 clk = ~clk;
   task automatic check(input string name, input logic exp, input logic got);
      n_compared++;
      if (got !== exp)
      begin
         fail_count++;
         $display("ERROR %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Back-to-back pushes, n cycles long
   task automatic push(input bit tx, input int n);
      @(negedge clk);
      if (tx) txp = 1'b1; else rxp = 1'b1;
      repeat (n) @(negedge clk);
      txp = 1'b0;
      rxp = 1'b0;
      repeat (2) @(negedge clk);
   endtask
   // Watchdog against a hang
   initial
   begin
      repeat (20000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
   initial
   begin
      repeat (12) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      // Pin function and serial path table
      foreach (rows[i])
      begin
         {sel, rts, stall, txb, hbit} = rows[i][9:3];
         we = 1'b1;
         @(negedge clk) we = 1'b0;
         repeat (2) @(negedge clk);
         check("permit", rows[i][2], perm);
         check("tx_allowed", rows[i][1], txa);
         if (!sel[1]) check("cts_in", rows[i][0], cts);
         check("serial_out", txb, sout);
         check("rx_bit", rows[i][2] | hbit, rxb);
      end
      sel = 3'h7;
      we = 1'b1;
      @(negedge clk) we = 1'b0;
      // Receive fill: permit drops two short of full
      push(1'b0, 13);
      check("permit_13", 1'b0, perm);
      push(1'b0, 1);
      check("permit_14", 1'b1, perm);
      push(1'b0, 3);
      check("rx_ovf", 1'b1, rxo);
      check("line_kept", 1'b1, line);
      @(negedge clk) ack = 1'b1;
      @(negedge clk) ack = 1'b0;
      check("rx_ack", 1'b0, rxo);
      // Transmit loss: only flagged while host idle
      push(1'b1, 17);
      check("tx_ctx", 1'b0, txo);
      snd = 1'b0;
      push(1'b1, 1);
      check("tx_ovf", 1'b1, txo);
      // Host pulls the line low: ignored here
      pull = 1'b1;
      repeat (3) @(negedge clk);
      check("line_low", 1'b0, line);
      check("no_hib", 1'b0, hib);
      pull = 1'b0;
      // Attention pin released to general use, pulled by software
      sel = 3'h3;
      gpl = 1'b1;
      we = 1'b1;
      @(negedge clk) we = 1'b0;
      repeat (2) @(negedge clk);
      check("gpio_oe", 1'b1, aoe);
      check("gpio_in", 1'b0, ain);
      gpl = 1'b0;
      // Second reset in mid-run
      rst = 1'b1;
      repeat (3) @(negedge clk);
      check("rst_out", 1'b1, sout);
      check("rst_oe", 1'b0, aoe);
      check("rst_flag", 1'b0, txo);
      rst = 1'b0;
      repeat (2) @(negedge clk);
      check("boot_line", 1'b1, line);
      print_verdict();
   end
endmodule
bind hsp_serial_pins hsp_serial_pins_monitor
   #(.ATTN_SUPPORTED(ATTN_SUPPORTED)) u_hsp_serial_pins_monitor (
   .CLK(CLK), .RST(RST), .HOST_SERIAL_OUT(HOST_SERIAL_OUT),
   .TX_BIT(TX_BIT), .LOCAL_RECEIVE_PERMIT_N(LOCAL_RECEIVE_PERMIT_N),
   .RX_PUSH_ACCEPT(RX_PUSH_ACCEPT), .TX_ALLOWED(TX_ALLOWED),
   .REMOTE_RECEIVE_PERMIT_N(REMOTE_RECEIVE_PERMIT_N),
   .ATTENTION_HIBERNATE_LINE_O(ATTENTION_HIBERNATE_LINE_O),
   .ATTENTION_HIBERNATE_LINE_OE(ATTENTION_HIBERNATE_LINE_OE),
   .HIBERNATE(HIBERNATE), .RX_PUSH(RX_PUSH), .TX_PUSH(TX_PUSH),
   .GPIO_ATTN_PULL_LOW(GPIO_ATTN_PULL_LOW),
   .HOST_SENDING(HOST_SENDING), .OVERFLOW_ACK(OVERFLOW_ACK),
   .RX_OVERFLOWED(RX_OVERFLOWED), .TX_OVERFLOWED(TX_OVERFLOWED));
`default_nettype wire
